/* hw/tdpr_top.sv */
/*
 Tag digit parallel reader: digit buffer, 4-line output, advance input,
 new-data flag and AXI4-Lite control. Assumes a tag front end on MCLK
 that streams digits after CAP_START; pins are asynchronous.
*/
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
// Summary of operation
// (RULE1) After reset and before capture, all four digit lines read high.
// (RULE2) Tag arrival starts a capture into the buffer without any request.
// (RULE3) Buffer holds digits until another tag or reset; tag may leave.
// (RULE4) Miniature mode: reset pulse clears buffer; present tag is recaptured.
// (RULE5) New-data flag rises at 4 digits, or 8 in miniature mode.
// (RULE6) New-data flag stays high until clear or next capture start.
// (RULE7) Controller waits for full capture before reading later digits.
// (RULE8) Broken capture leaves value F in every remaining digit position.
// (RULE9) Digit shown in binary on four lines, weights 1, 2, 4, 8.
// (RULE10) First buffered digit appears at once, no advance needed.
// (RULE11) Each advance moves to next digit; 32 standard, 8 miniature.
// (RULE12) Advance counts on rising edge; new capture resets pointer.
// (RULE13) Advance held high blocks any digit transfer into the buffer.
// (RULE14) Advance falling after early tag arrival triggers the capture.
// (RULE15) Advance held high keeps the new-data flag output low.
// (RULE16) Static-read controller senses tag presence by its own means.
`timescale 1ns/1ps
`default_nettype none
module tdpr_top
    import tdpr_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic TAG_PRESENT,
    input wire logic ADV_IN,
    input wire logic CLR_PULSE,
    input wire logic DIG_VALID,
    input wire logic [DIG_W-1:0] DIG_DATA,
    input wire logic DIG_FAIL,
    output logic CAP_START,
    output logic [DIG_W-1:0] DATA_OUT,
    output logic STROBE,
    output logic IRQ,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    logic prs;
    logic skp;
    logic clp;
    tdpr_sync u_sync_prs (.clk(MCLK), .rst_n(RST_N), .d(TAG_PRESENT), .q(prs));
    tdpr_sync u_sync_skp (.clk(MCLK), .rst_n(RST_N), .d(ADV_IN), .q(skp));
    tdpr_sync u_sync_clp (.clk(MCLK), .rst_n(RST_N), .d(CLR_PULSE), .q(clp));

    tdpr_state_t state_reg, state_next;
    logic [DIG_W-1:0] buf_reg [BUF_DEPTH];
    logic [DIG_W-1:0] buf_next [BUF_DEPTH];
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [PTR_W-1:0] ptr_reg, ptr_next;
    logic flag_reg, flag_next;
    logic err_reg, err_next;
    logic pend_reg, pend_next;
    logic prs_prev_reg, skp_prev_reg, clp_prev_reg;
    logic cap_reg, cap_next;
    logic [DIG_W-1:0] dout_reg, dout_next;
    logic strobe_reg, strobe_next;
    logic mini_reg, mini_next;
    logic soft_clr;
    logic clr_req, start_go, dig_take, abort;
    logic [CNT_W-1:0] thr, num;
    logic [PTR_W-1:0] last;
    logic [IRQ_W-1:0] ev;

    always_comb begin
        thr = mini_reg ? THR_MINI : THR_STD;
        num = mini_reg ? NUM_MINI : NUM_STD;
        last = mini_reg ? LAST_MINI : LAST_STD;
        state_next = state_reg;
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        ptr_next = ptr_reg;
        flag_next = flag_reg;
        err_next = err_reg;
        pend_next = pend_reg;
        cap_next = 1'b0;
        ev = '0;
        clr_req = (mini_reg && clp && !clp_prev_reg) || soft_clr; // RULE4
        if (prs && !prs_prev_reg) begin
            pend_next = 1'b1; // RULE2
        end
        if (!prs) begin
            pend_next = 1'b0;
        end
        // Held advance delays the start until its fall
        start_go = !clr_req && pend_reg && prs && !skp
            && (state_reg != TDPR_CAPT); // RULE2 RULE13 RULE14
        dig_take = (state_reg == TDPR_CAPT) && DIG_VALID && !skp; // RULE13
        abort = (state_reg == TDPR_CAPT) && (!prs || DIG_FAIL);
        if (skp && !skp_prev_reg && ptr_reg < last) begin
            ptr_next = ptr_reg + 5'h01; // RULE11 RULE12
        end
        case (state_reg)
            TDPR_IDLE, TDPR_HOLD: begin
                if (start_go) begin
                    // Blank fill makes any unread position read as F
                    for (int i = 0; i < BUF_DEPTH; i++) begin
                        buf_next[i] = DIGIT_BLANK; // RULE8
                    end
                    cnt_next = '0;
                    ptr_next = '0; // RULE10 RULE12
                    flag_next = 1'b0; // RULE6
                    err_next = 1'b0;
                    pend_next = 1'b0;
                    cap_next = 1'b1;
                    ev[IRQ_ARRIVE_BIT] = 1'b1;
                    state_next = TDPR_CAPT;
                end
            end
            TDPR_CAPT: begin
                if (dig_take) begin
                    buf_next[cnt_reg[PTR_W-1:0]] = DIG_DATA; // RULE2
                    cnt_next = cnt_reg + 6'h01;
                    if (cnt_next == thr) begin
                        flag_next = 1'b1; // RULE5
                    end
                    if (cnt_next >= num) begin
                        ev[IRQ_DONE_BIT] = 1'b1;
                        state_next = TDPR_HOLD; // RULE3
                    end
                end
                if (abort && state_next == TDPR_CAPT) begin
                    // Flag raised so the controller still sees the F digits
                    err_next = 1'b1; // RULE8
                    flag_next = 1'b1;
                    ev[IRQ_ERR_BIT] = 1'b1;
                    state_next = TDPR_HOLD;
                end
            end
            default: begin
                state_next = TDPR_IDLE;
            end
        endcase
        if (clr_req) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_next[i] = DIGIT_BLANK; // RULE4
            end
            cnt_next = '0;
            ptr_next = '0;
            flag_next = 1'b0;
            err_next = 1'b0;
            pend_next = prs; // RULE4
            state_next = TDPR_IDLE;
        end
        dout_next = buf_next[ptr_next]; // RULE9 RULE10
        strobe_next = flag_next && !skp; // RULE15
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= TDPR_IDLE;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_reg[i] <= DIGIT_BLANK;
            end
            cnt_reg <= '0;
            ptr_reg <= '0;
            flag_reg <= 1'b0;
            err_reg <= 1'b0;
            pend_reg <= 1'b0;
            prs_prev_reg <= 1'b0;
            skp_prev_reg <= 1'b0;
            clp_prev_reg <= 1'b0;
            cap_reg <= 1'b0;
            dout_reg <= DIGIT_BLANK; // RULE1
            strobe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
            ptr_reg <= ptr_next;
            flag_reg <= flag_next;
            err_reg <= err_next;
            pend_reg <= pend_next;
            prs_prev_reg <= prs;
            skp_prev_reg <= skp;
            clp_prev_reg <= clp;
            cap_reg <= cap_next;
            dout_reg <= dout_next;
            strobe_reg <= strobe_next;
        end
    end

    // AXI4-Lite slave, one write and one read in flight
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next, stat_word;
    logic [IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
    logic irq_reg, irq_next, clr_reg, clr_next, wen;

    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        mini_next = mini_reg;
        imask_next = imask_reg;
        clr_next = 1'b0;
        wen = 1'b0;
        stat_word = '0;
        stat_word[STAT_STROBE_BIT] = flag_reg;
        stat_word[STAT_CAPT_BIT] = (state_reg == TDPR_CAPT);
        stat_word[STAT_ERR_BIT] = err_reg;
        stat_word[STAT_PEND_BIT] = pend_reg;
        stat_word[STAT_PTR_LSB +: PTR_W] = ptr_reg;
        stat_word[STAT_CNT_LSB +: CNT_W] = cnt_reg;
        if (S_AXI_AWVALID && awready_reg) begin
            aw_have_next = 1'b1;
            aw_addr_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_reg) begin
            w_have_next = 1'b1;
            w_data_next = S_AXI_WDATA;
            w_strb_next = S_AXI_WSTRB;
        end
        if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_next = 1'b0;
        end
        if (aw_have_reg && w_have_reg && !bvalid_reg) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            wen = w_strb_reg[0];
            case (aw_addr_reg)
                CTRL_OFF: begin
                    if (wen) begin
                        mini_next = w_data_reg[CTRL_MINI_BIT];
                        clr_next = w_data_reg[CTRL_CLR_BIT];
                    end
                end
                IMASK_OFF: begin
                    if (wen) begin
                        imask_next = w_data_reg[IRQ_W-1:0];
                    end
                end
                ISTAT_OFF, STAT_OFF, DIGIT_OFF: begin
                end
                default: begin
                    bresp_next = RESP_SLVERR;
                    wen = 1'b0;
                end
            endcase
        end
        // Set wins over a same-cycle write-one clear
        istat_next = istat_reg;
        if (wen && aw_addr_reg == ISTAT_OFF) begin
            istat_next = istat_reg & ~w_data_reg[IRQ_W-1:0];
        end
        istat_next = istat_next | ev;
        irq_next = |(istat_next & imask_next);
        if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_next = 1'b0;
        end
        if (S_AXI_ARVALID && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (S_AXI_ARADDR)
                CTRL_OFF: rdata_next = {31'h0, mini_reg};
                STAT_OFF: rdata_next = stat_word;
                ISTAT_OFF: rdata_next = {29'h0, istat_reg};
                IMASK_OFF: rdata_next = {29'h0, imask_reg};
                DIGIT_OFF: rdata_next = {28'h0, dout_reg};
                default: begin
                    rdata_next = '0;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
        awready_next = !aw_have_next;
        wready_next = !w_have_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_have_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            mini_reg <= RST_MINI;
            istat_reg <= RST_IRQ;
            imask_reg <= RST_IRQ;
            irq_reg <= 1'b0;
            clr_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            mini_reg <= mini_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            irq_reg <= irq_next;
            clr_reg <= clr_next;
        end
    end

    assign soft_clr = clr_reg;
    assign CAP_START = cap_reg;
    assign DATA_OUT = dout_reg;
    assign STROBE = strobe_reg;
    assign IRQ = irq_reg;
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign S_AXI_RDATA = rdata_reg;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_adv_held;
        skp ##1 skp;
    endsequence
    sequence s_last_digit;
        dig_take && !abort && !clr_req && (cnt_reg + 6'h01 == thr);
    endsequence

    property p_blank;
        cnt_reg == '0 |-> DATA_OUT == DIGIT_BLANK;
    endproperty
    a_blank: assert property (p_blank) else $error("blank digit"); // RULE1
    property p_start;
        start_go |=> state_reg == TDPR_CAPT && CAP_START && ptr_reg == '0;
    endproperty
    a_start: assert property (p_start) else $error("no start"); // RULE2
    property p_hold;
        state_reg == TDPR_HOLD && !start_go && !clr_req |=> $stable(cnt_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("buffer lost"); // RULE3
    property p_clear;
        clr_req |=> cnt_reg == '0 && !flag_reg ##1 !STROBE;
    endproperty
    a_clear: assert property (p_clear) else $error("no clear"); // RULE4
    property p_flag_rise;
        s_last_digit |=> flag_reg;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag late"); // RULE5
    property p_flag_keep;
        flag_reg && !clr_req && !start_go |=> flag_reg;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag drop"); // RULE6
    property p_abort;
        abort && !clr_req && !(dig_take && cnt_reg + 6'h01 >= num)
            |=> err_reg && state_reg == TDPR_HOLD;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort"); // RULE8
    property p_digit_out;
        dig_take && !clr_req && cnt_reg[PTR_W-1:0] == ptr_reg
            |=> DATA_OUT == $past(DIG_DATA);
    endproperty
    a_digit_out: assert property (p_digit_out) else $error("bad digit"); // RULE9
    property p_advance;
        skp && !skp_prev_reg && ptr_reg < last && !start_go && !clr_req
            |=> ptr_reg == $past(ptr_reg) + 5'h01;
    endproperty
    a_advance: assert property (p_advance) else $error("no advance"); // RULE11
    property p_no_xfer;
        skp && state_reg == TDPR_CAPT && !clr_req |=> cnt_reg == $past(cnt_reg);
    endproperty
    a_no_xfer: assert property (p_no_xfer) else $error("xfer held"); // RULE13
    property p_strobe_low;
        s_adv_held |-> !STROBE;
    endproperty
    a_strobe_low: assert property (p_strobe_low) else $error("strobe hi"); // RULE15
endmodule
`default_nettype wire

/* hw/tdpr_pkg.sv */
/*
 Constants, offsets and types shared by the tag digit parallel reader.
 Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package tdpr_pkg;
    localparam int DIG_W = 4;
    localparam int BUF_DEPTH = 32;
    localparam int PTR_W = 5;
    localparam int CNT_W = 6;
    localparam int ADDR_W = 8;
    localparam int IRQ_W = 3;
    localparam logic [CNT_W-1:0] NUM_STD = 6'h20;
    localparam logic [CNT_W-1:0] NUM_MINI = 6'h08;
    localparam logic [CNT_W-1:0] THR_STD = 6'h04;
    localparam logic [CNT_W-1:0] THR_MINI = 6'h08;
    localparam logic [PTR_W-1:0] LAST_STD = 5'h1f;
    localparam logic [PTR_W-1:0] LAST_MINI = 5'h07;
    localparam logic [DIG_W-1:0] DIGIT_BLANK = 4'hf;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] ISTAT_OFF = 8'h08;
    localparam logic [ADDR_W-1:0] IMASK_OFF = 8'h0c;
    localparam logic [ADDR_W-1:0] DIGIT_OFF = 8'h10;
    // Field positions
    localparam int CTRL_MINI_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int STAT_STROBE_BIT = 0;
    localparam int STAT_CAPT_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_PEND_BIT = 3;
    localparam int STAT_PTR_LSB = 8;
    localparam int STAT_CNT_LSB = 16;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_ARRIVE_BIT = 2;
    // Reset values and AXI response codes
    localparam logic RST_MINI = 1'b0;
    localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        TDPR_IDLE = 3'b001,
        TDPR_CAPT = 3'b010,
        TDPR_HOLD = 3'b100
    } tdpr_state_t;
endpackage

/* hw/tdpr_sync.sv */
/*
 Three-stage input synchroniser with agreement filter.
 Assumes an asynchronous pin input and the block's single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tdpr_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic q_reg;
    logic q_next;

    always_comb begin
        // Change counts only once stages two and three agree
        q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_reg <= 1'b0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule
`default_nettype wire

/* bench/tdpr_front.sv */
/*
 Behavioural tag front end facing the reader's digit stream port.
 Assumes the reader's clock and CAP_START pulse; the bench owns presence.
*/
`timescale 1ns/1ps
`default_nettype none
module tdpr_front (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cap_start,
    input wire logic present,
    input wire logic [5:0] fail_at,
    output logic dig_valid,
    output logic [3:0] dig_data,
    output logic dig_fail
);
    logic [5:0] idx_reg;
    logic [1:0] gap_reg;
    logic run_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg <= 6'h00;
            gap_reg <= 2'h0;
            run_reg <= 1'b0;
            dig_valid <= 1'b0;
            dig_data <= 4'h0;
            dig_fail <= 1'b0;
        end else begin
            dig_valid <= 1'b0;
            dig_fail <= 1'b0;
            // Idle data lines do not hold the last digit
            dig_data <= ~dig_data;
            gap_reg <= gap_reg + 2'h1;
            if (cap_start) begin
                run_reg <= 1'b1;
                idx_reg <= 6'h00;
                gap_reg <= 2'h0;
            end else if (run_reg && gap_reg == 2'h3) begin
                if (!present || idx_reg == fail_at) begin
                    dig_fail <= 1'b1;
                    run_reg <= 1'b0;
                end else begin
                    dig_valid <= 1'b1;
                    dig_data <= 4'(idx_reg * 7 + 3);
                    idx_reg <= idx_reg + 6'h01;
                    if (idx_reg == 6'h1f) begin
                        run_reg <= 1'b0;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* bench/tb.sv */
/*
 Self-checking bench for the tag digit parallel reader.
 Assumes tdpr_pkg, tdpr_top and the tdpr_front model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tdpr_pkg::*;
    logic MCLK = 1'b0;
    logic RST_N, TAG_PRESENT, ADV_IN, CLR_PULSE;
    logic dig_valid, dig_fail, cap_start, strobe, irq;
    logic [3:0] dig_data, data_out;
    logic [5:0] fail_at;
    logic [7:0] aw_a, ar_a;
    logic [31:0] w_d, r_d, rd;
    logic aw_v, w_v, b_r, ar_v, r_r, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    logic [1:0] b_resp, r_resp, rs;
    int errors = 0;
    int comparisons = 0;
    int starts = 0;
    always #10 MCLK = ~MCLK;
    tdpr_top dut (.MCLK(MCLK), .RST_N(RST_N), .TAG_PRESENT(TAG_PRESENT),
        .ADV_IN(ADV_IN), .CLR_PULSE(CLR_PULSE), .DIG_VALID(dig_valid),
        .DIG_DATA(dig_data), .DIG_FAIL(dig_fail), .CAP_START(cap_start),
        .DATA_OUT(data_out), .STROBE(strobe), .IRQ(irq),
        .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
        .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v),
        .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v),
        .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v),
        .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp),
        .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r));
    tdpr_front front (.clk(MCLK), .rst_n(RST_N), .cap_start(cap_start),
        .present(TAG_PRESENT), .fail_at(fail_at), .dig_valid(dig_valid),
        .dig_data(dig_data), .dig_fail(dig_fail));
    always @(posedge MCLK) begin
        if (cap_start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    function automatic logic [3:0] dig(input int i);
        return 4'(i * 7 + 3);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge MCLK);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        while (b_v !== 1'b1) begin
            @(posedge MCLK);
            if (aw_rdy === 1'b1) aw_v <= 1'b0;
            if (w_rdy === 1'b1) w_v <= 1'b0;
        end
        r = b_resp;
        b_r <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge MCLK);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        while (r_v !== 1'b1) begin
            @(posedge MCLK);
            if (ar_rdy === 1'b1) ar_v <= 1'b0;
        end
        d = r_d;
        r = r_resp;
        r_r <= 1'b0;
    endtask
    // Pin passes a three-stage filter, so hold each level 8 cycles
    task automatic advance();
        @(posedge MCLK);
        ADV_IN <= 1'b1;
        repeat (8) @(posedge MCLK);
        ADV_IN <= 1'b0;
        repeat (8) @(posedge MCLK);
    endtask
    task automatic expect_start(input int s0);
        for (int n = 0; n < 60 && starts == s0; n++) @(posedge MCLK);
        check(32'(starts - s0), 32'd1);
        repeat (2) @(posedge MCLK);
        check(32'(strobe), 32'd0);
    endtask
    task automatic wait_strobe();
        for (int n = 0; n < 100 && strobe !== 1'b1; n++) @(posedge MCLK);
        check(32'(strobe), 32'd1);
    endtask
    task automatic step_all(input int last);
        for (int i = 1; i <= last + 1; i++) begin
            advance();
            check(32'(data_out), 32'(dig(i > last ? last : i)));
        end
    endtask
    task automatic t_standard();
        axi_wr(IMASK_OFF, 32'h1, rs);
        TAG_PRESENT <= 1'b1;
        expect_start(starts);
        wait_strobe();
        check(32'(data_out), 32'(dig(0)));
        // Full stream needs 32 digits at four cycles each
        repeat (200) @(posedge MCLK);
        check(32'(irq), 32'd1);
        TAG_PRESENT <= 1'b0;
        repeat (20) @(posedge MCLK);
        check(32'(data_out), 32'(dig(0)));
        step_all(31);
        axi_rd(DIGIT_OFF, rd, rs);
        check(rd, 32'(dig(31)));
        axi_wr(ISTAT_OFF, 32'h7, rs);
        @(posedge MCLK);
        check(32'(irq), 32'd0);
    endtask
    task automatic t_abort();
        fail_at <= 6'd6;
        TAG_PRESENT <= 1'b1;
        expect_start(starts);
        wait_strobe();
        check(32'(data_out), 32'(dig(0)));
        repeat (60) @(posedge MCLK);
        TAG_PRESENT <= 1'b0;
        fail_at <= 6'h3f;
        for (int i = 1; i < 9; i++) begin
            advance();
            check(32'(data_out), i < 6 ? 32'(dig(i)) : 32'hf);
        end
    endtask
    task automatic t_static();
        int s0;
        s0 = starts;
        ADV_IN <= 1'b1;
        repeat (10) @(posedge MCLK);
        TAG_PRESENT <= 1'b1;
        repeat (60) @(posedge MCLK);
        check(32'(starts - s0), 32'd0);
        check(32'(strobe), 32'd0);
        ADV_IN <= 1'b0;
        expect_start(s0);
        wait_strobe();
        repeat (200) @(posedge MCLK);
        TAG_PRESENT <= 1'b0;
        repeat (20) @(posedge MCLK);
        check(32'(data_out), 32'(dig(0)));
    endtask
    task automatic t_mini();
        int s0;
        axi_wr(CTRL_OFF, 32'h1, rs);
        TAG_PRESENT <= 1'b1;
        expect_start(starts);
        wait_strobe();
        axi_rd(STAT_OFF, rd, rs);
        check(32'(rd[21:16]), 32'(THR_MINI));
        // Tag stays in range, so the clear must restart capture
        s0 = starts;
        CLR_PULSE <= 1'b1;
        repeat (8) @(posedge MCLK);
        CLR_PULSE <= 1'b0;
        expect_start(s0);
        wait_strobe();
        repeat (10) @(posedge MCLK);
        TAG_PRESENT <= 1'b0;
        repeat (20) @(posedge MCLK);
        check(32'(data_out), 32'(dig(0)));
        step_all(7);
        axi_wr(CTRL_OFF, 32'h3, rs);
        repeat (4) @(posedge MCLK);
        check(32'(data_out), 32'hf);
    endtask
    initial begin
        RST_N = 1'b0;
        {TAG_PRESENT, ADV_IN, CLR_PULSE, aw_v, w_v, b_r, ar_v, r_r} = 8'h00;
        {aw_a, ar_a, w_d} = 48'h0;
        fail_at = 6'h3f;
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (2) @(posedge MCLK);
        check(32'(data_out), 32'hf);
        check(32'(strobe), 32'd0);
        t_standard();
        t_abort();
        t_static();
        t_mini();
        axi_rd(8'h40, rd, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        axi_wr(8'h44, 32'h1, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
